// ---- src/dsp_core.sv ----
// How it works
// RQ1 - read bits shift into 16-bit converter
// RQ2 - word strobe copies word to read buffer
// RQ3 - read of data port returns buffer
// RQ4 - sync byte precedes each id, data field
// RQ5 - sync 19h, d9h for marked data
// RQ6 - sync pattern flags active-low sync seen
// RQ7 - lock sets on next bit clock
// RQ8 - lock starts word clock, enables sequencing
// RQ9 - hold 32-bit target sector id
// RQ10 - processor loads id by two writes
// RQ11 - compare id bits after id sync
// RQ12 - id mismatch low on differing bit
// RQ13 - or mismatches, latch into status bit 6
// RQ14 - bit 6 high means wrong or bad
// RQ15 - append four-byte check on writes
// RQ16 - delayed transfer feeds generator and output
// RQ17 - check window sends generated bits out
// RQ18 - read check difference shifts into converter
// RQ19 - zero difference raises combined line high
// RQ20 - status reads drive bus lines 8-15
// RQ21 - status upper byte drive and board bits
// RQ22 - status lower byte controller bits
// RQ23 - auxiliary byte drive and option bits
// RQ24 - latched mismatch holds until next field
// RQ25 - written words load serializer on word clock
`default_nettype none
module dsp_core
    import dsp_pkg::*;
#(
    parameter int BIT_DIV = dsp_pkg::DSP_BIT_DIV
)(
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // processor i/o port
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_rd_i,
    input  wire logic        io_wr_i,
    input  wire logic [15:0] io_wdata_i,
    output logic      [15:0] internal_bus_lines_o,
    // sequencing control
    input  wire logic        read_gate_i,
    input  wire logic        write_transfer_n_i,
    input  wire logic        delayed_write_transfer_i,
    input  wire logic        ecc_window_i,
    input  wire logic        id_field_i,
    input  wire logic        addr_mark_mode_i,
    // drive serial lines and pins
    input  wire logic        serial_read_i,
    output logic             serial_write_stream_o,
    input  wire logic [7:0]  drive_status_i,
    input  wire logic [5:0]  ctrl_status_i,
    input  wire logic [5:0]  aux_status_i,
    // status to sequencing logic
    output logic             sync_locked_o,
    output logic             word_load_strobe_o,
    output logic             latched_mismatch_o
);
    import dsp_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] rd_sync;
    logic [7:0] drv_s1, drv_s2;
    logic [5:0] ctl_s1, ctl_s2, aux_s1, aux_s2;
    logic [4:0] seq_s1, seq_s2;
    logic       rd_bit;

    // pins cross in from the drive, two stages each
    always_ff @(posedge sys_clk_i)
    begin
        rd_sync <= {rd_sync[0], serial_read_i};
        drv_s1  <= drive_status_i;
        drv_s2  <= drv_s1;
        ctl_s1  <= ctrl_status_i;
        ctl_s2  <= ctl_s1;
        aux_s1  <= aux_status_i;
        aux_s2  <= aux_s1;
        seq_s1  <= {read_gate_i, write_transfer_n_i,
                    delayed_write_transfer_i, ecc_window_i, id_field_i};
        seq_s2  <= seq_s1;
    end
    assign rd_bit = rd_sync[1];

    logic rd_gate, wr_xfer_n, wr_dly, ecc_win, id_fld;
    assign rd_gate   = seq_s2[4];
    assign wr_xfer_n = seq_s2[3];
    assign wr_dly    = seq_s2[2];
    assign ecc_win   = seq_s2[1];
    assign id_fld    = seq_s2[0];

    // ----------------------------------------
    // bit shift clock enable
    // ----------------------------------------
    logic [$clog2(BIT_DIV)-1:0] div_cnt;
    logic                       bit_en;

    // one pulse per serial bit cell
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            div_cnt <= '0;
        else if (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1))
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end
    assign bit_en = (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1));

    // ----------------------------------------
    // shift converter and sync detect
    // ----------------------------------------
    logic [15:0] shift_converter;
    logic [15:0] read_buffer;
    logic [15:0] write_buffer;
    logic        sync_seen_n;
    logic        sync_locked;
    logic [3:0]  word_bit;
    logic        word_end;
    logic        ser_in;
    logic        ecc_diff;
    logic        writing;
    logic        lock_set;

    assign writing = ~wr_xfer_n;
    // the bit shifted in on the locking edge is already field data
    assign lock_set = bit_en && !sync_seen_n && rd_gate && !sync_locked;

    // read path: shift low byte compared against sync
    assign sync_seen_n =
        ~(shift_converter[7:0] == DSP_SYNC_STD ||
          (addr_mark_mode_i && !id_fld &&
           shift_converter[7:0] == DSP_SYNC_AM_DATA));      // RQ5 RQ6
    // first word bit lands on the lock edge, one before the count starts
    assign word_end = sync_locked && bit_en && (word_bit == 4'hE);

    // input to the converter: data, or check difference in window
    assign ser_in = ecc_win ? ecc_diff : rd_bit;            // RQ18

    // converter shifts msb first; write loads on word boundary, or on every bit cell while unlocked
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            shift_converter <= 16'h0000;
        else if (bit_en)
        begin
            if (writing && (word_end || !sync_locked))
                shift_converter <= write_buffer;            // RQ25
            else
                shift_converter <= {shift_converter[14:0], ser_in}; // RQ1
        end
    end

    // lock on the bit clock after sync seen; drops with the gates
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || (!rd_gate && wr_xfer_n))
            sync_locked <= 1'b0;
        else if (bit_en && !sync_seen_n && rd_gate)
            sync_locked <= 1'b1;                            // RQ7
    end

    // word clock only counts once locked, aligning words to data
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !sync_locked)
            word_bit <= 4'h0;
        else if (bit_en)
            word_bit <= word_bit + 1'b1;                    // RQ8
    end

    // read buffer captures whole word at the strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            read_buffer <= 16'h0000;
        else if (word_end && !writing)
            read_buffer <= {shift_converter[14:0], ser_in}; // RQ2
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            word_load_strobe_o <= 1'b0;
            sync_locked_o      <= 1'b0;
        end
        else
        begin
            word_load_strobe_o <= word_end;
            sync_locked_o      <= sync_locked;                  // RQ8
        end
    end

    // ----------------------------------------
    // port decode and write side
    // ----------------------------------------
    logic        data_port_write_decode;
    logic        data_port_read_decode;
    logic        status_word_read_decode;
    logic        aux_status_read_decode;
    logic        id_load_strobe_first;
    logic        id_load_strobe_second;
    logic [31:0] target_id;

    always_comb
    begin
        data_port_write_decode  = 1'b0;
        data_port_read_decode   = 1'b0;
        status_word_read_decode = 1'b0;
        aux_status_read_decode  = 1'b0;
        id_load_strobe_first    = 1'b0;
        id_load_strobe_second   = 1'b0;
        if (io_addr_i == DSP_ADDR_DATA)
        begin
            data_port_write_decode = io_wr_i;
            data_port_read_decode  = io_rd_i;
        end
        else if (io_addr_i == DSP_ADDR_STATUS)
            status_word_read_decode = io_rd_i;
        else if (io_addr_i == DSP_ADDR_AUX)
            aux_status_read_decode = io_rd_i;
        else if (io_addr_i == DSP_ADDR_ID_LO)
            id_load_strobe_first = io_wr_i;
        else if (io_addr_i == DSP_ADDR_ID_HI)
            id_load_strobe_second = io_wr_i;
    end

    // write buffer only meaningful while transfer is active
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            write_buffer <= 16'h0000;
        else if (data_port_write_decode && writing)
            write_buffer <= io_wdata_i;                     // RQ25
    end

    // target id: first write high half, second low half
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            target_id <= 32'h0000_0000;
        else if (id_load_strobe_first)
            target_id[31:16] <= io_wdata_i;                 // RQ9 RQ10
        else if (id_load_strobe_second)
            target_id[15:0] <= io_wdata_i;                  // RQ9
    end

    // ----------------------------------------
    // id compare
    // ----------------------------------------
    logic [31:0] id_shift;
    logic [5:0]  id_cnt;
    logic        id_mismatch_n;
    logic        id_active;

    assign id_active = (sync_locked || lock_set) && id_fld && !ecc_win
                       && !writing;

    // copy reloaded while unlocked so each new field starts fresh
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            id_shift      <= 32'h0000_0000;
            id_cnt        <= 6'd0;
            id_mismatch_n <= 1'b1;
        end
        else if (!sync_locked && !lock_set)
        begin
            id_shift      <= target_id;
            id_cnt        <= 6'd0;
            id_mismatch_n <= 1'b1;
        end
        else if (bit_en && id_active && id_cnt != 6'(DSP_ID_BITS))
        begin
            id_shift <= {id_shift[30:0], 1'b0};             // RQ11
            id_cnt   <= id_cnt + 1'b1;
            if (id_shift[31] != rd_bit)
                id_mismatch_n <= 1'b0;                      // RQ12
        end
    end

    // ----------------------------------------
    // check code generator
    // ----------------------------------------
    logic [31:0] ecc_reg;
    logic        ecc_fb;
    logic        ecc_data_bit;
    logic        check_mismatch_n;
    logic        combined_mismatch_n;
    logic        serial_out;

    assign ecc_data_bit = writing ? (shift_converter[15] & wr_dly) : rd_bit;
    assign ecc_fb   = ecc_reg[31] ^ ecc_data_bit;
    assign ecc_diff = ecc_reg[31] ^ rd_bit;

    // lfsr runs over the field, then shifts out in the window
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !(sync_locked || lock_set))
            ecc_reg <= DSP_ECC_SEED;
        else if (bit_en && ecc_win)
            ecc_reg <= {ecc_reg[30:0], 1'b0};               // RQ15
        else if (bit_en && (wr_dly || !writing))
            ecc_reg <= {ecc_reg[30:0], 1'b0}
                       ^ (ecc_fb ? DSP_ECC_POLY : 32'h0);   // RQ16 RQ18
    end

    // any differing check bit in the window marks a mismatch
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !sync_locked)
            check_mismatch_n <= 1'b1;
        else if (bit_en && ecc_win && !writing && ecc_diff)
            check_mismatch_n <= 1'b0;                       // RQ19
    end

    assign combined_mismatch_n = id_mismatch_n & check_mismatch_n; // RQ13

    // mismatch reloaded every cycle of the locked window; held until the next locked window
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            latched_mismatch_o <= 1'b0;
        else if (sync_locked && ecc_win && !writing)
            latched_mismatch_o <= ~combined_mismatch_n;     // RQ13 RQ24
    end

    // sync byte leads each field through the data path
    assign serial_out = ecc_win ? ecc_reg[31]               // RQ17
                      : (shift_converter[15] & wr_dly);     // RQ4 RQ16

    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            serial_write_stream_o <= 1'b0;
        else
            serial_write_stream_o <= writing ? serial_out : 1'b0;
    end

    // ----------------------------------------
    // status and read mux
    // ----------------------------------------
    logic [15:0] status_word;
    logic [15:0] aux_word;

    always_comb
    begin
        status_word = {drv_s2, 8'h00};                      // RQ21
        status_word[DSP_ST_TIMEOUT] = ctl_s2[5];            // RQ22
        status_word[DSP_ST_NOCMP]   = latched_mismatch_o;   // RQ14
        status_word[DSP_ST_BUSACK]  = ctl_s2[3];
        status_word[DSP_ST_FAULT]   = ctl_s2[2];
        status_word[DSP_ST_DSYNC]   = ctl_s2[1];
        status_word[DSP_ST_SEEKC]   = ctl_s2[0];
        aux_word = {aux_s2, 2'b00, 8'h00};                  // RQ23
    end

    // status drive byte sits on bus lines 8-15, controller byte on lines 0-7
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
            internal_bus_lines_o <= 16'h0000;
        else if (data_port_read_decode)
            internal_bus_lines_o <= read_buffer;            // RQ3
        else if (status_word_read_decode)
            internal_bus_lines_o <= status_word;            // RQ20
        else if (aux_status_read_decode)
            internal_bus_lines_o <= aux_word;               // RQ20
        else
            internal_bus_lines_o <= 16'h0000;
    end
endmodule
`default_nettype wire

// ---- src/dsp_pkg.sv ----
`default_nettype none
package dsp_pkg;
    // i/o port addresses
    localparam logic [15:0] DSP_ADDR_STATUS  = 16'h8000;
    localparam logic [15:0] DSP_ADDR_AUX     = 16'h8008;
    localparam logic [15:0] DSP_ADDR_DATA    = 16'h8028;
    localparam logic [15:0] DSP_ADDR_ID_LO   = 16'h8030;
    localparam logic [15:0] DSP_ADDR_ID_HI   = 16'h8038;
    // sync byte values
    localparam logic [7:0]  DSP_SYNC_STD     = 8'h19;
    localparam logic [7:0]  DSP_SYNC_AM_DATA = 8'hD9;
    // field sizes
    localparam int          DSP_WORD_BITS    = 16;
    localparam int          DSP_ID_BITS      = 32;
    localparam int          DSP_ECC_BITS     = 32;
    localparam logic [31:0] DSP_ECC_POLY     = 32'h0104C981;
    localparam logic [31:0] DSP_ECC_SEED     = 32'h00000000;
    // status word field positions
    localparam int          DSP_ST_TIMEOUT   = 7;
    localparam int          DSP_ST_NOCMP     = 6;
    localparam int          DSP_ST_BUSACK    = 5;
    localparam int          DSP_ST_FAULT     = 4;
    localparam int          DSP_ST_DSYNC     = 3;
    localparam int          DSP_ST_SEEKC     = 2;
    // bit-clock divider default
    localparam int          DSP_BIT_DIV      = 4;
endpackage
`default_nettype wire

// ---- test/dsp_checker.sv ----
`default_nettype none
module dsp_checker
    import dsp_pkg::*;
(
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    // processor port
    input wire logic [15:0] io_addr_i,
    input wire logic        io_rd_i,
    input wire logic [15:0] internal_bus_lines_o,
    // status sources and results
    input wire logic        ecc_window_i,
    input wire logic [7:0]  drive_status_i,
    input wire logic [5:0]  ctrl_status_i,
    input wire logic [5:0]  aux_status_i,
    input wire logic        sync_locked_o,
    input wire logic        word_load_strobe_o,
    input wire logic        latched_mismatch_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // port checks
    // ----------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [15:0] bus;
    logic        st_rd;
    logic        ax_rd;
    // short aliases keep each property readable
    assign bus   = internal_bus_lines_o;
    assign st_rd = io_rd_i && io_addr_i == DSP_ADDR_STATUS;
    assign ax_rd = io_rd_i && io_addr_i == DSP_ADDR_AUX;
    chk_bus_idle_zero: assert property (
        !io_rd_i |=> bus == 16'h0000)
        else $error("bus not zero after idle cycle");
    chk_unmapped_zero: assert property (
        io_rd_i && io_addr_i[15:8] != 8'h80 |=> bus == 16'h0000)
        else $error("unmapped read returned data");
    // inputs pass two synchronisers, so demand four quiet cycles first
    chk_status_upper: assert property (
        $stable(drive_status_i)[*4] ##0 st_rd
        |=> bus[15:8] == $past(drive_status_i))
        else $error("status upper byte wrong");
    chk_status_lower: assert property (
        $stable(ctrl_status_i)[*4] ##0 st_rd
        |=> {bus[7], bus[5:2]}
            == $past({ctrl_status_i[5], ctrl_status_i[3:0]}))
        else $error("status lower byte wrong");
    chk_aux_byte: assert property (
        $stable(aux_status_i)[*4] ##0 ax_rd
        |=> bus[15:10] == $past(aux_status_i))
        else $error("aux status byte wrong");
    chk_mismatch_bit: assert property (
        st_rd |=> bus[6] == $past(latched_mismatch_o))
        else $error("status bit 6 differs from mismatch");
    chk_strobe_pulse: assert property (
        word_load_strobe_o |=> !word_load_strobe_o [*8])
        else $error("word strobe too long or too close");
    chk_strobe_locked: assert property (
        word_load_strobe_o |-> sync_locked_o)
        else $error("word strobe without lock");
    // window input lags inside, so six idle cycles before holding
    chk_mismatch_hold: assert property (
        (!ecc_window_i && !sync_locked_o)[*6]
        |-> $stable(latched_mismatch_o))
        else $error("mismatch changed outside window");
    cov_lock: cover property ($rose(sync_locked_o));
    cov_mismatch: cover property ($rose(latched_mismatch_o));
    cov_strobe: cover property (word_load_strobe_o);
endmodule
`default_nettype wire

// ---- test/dsp_drive_model.sv ----
`default_nettype none
module dsp_drive_model #(
    parameter int BIT_DIV = 4
)(
    // bit timing reference
    input  wire logic sys_clk_i,
    // serial read data toward the block
    output var logic  serial_read_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // bit cell engine
    // ----------
    logic q[$];
    int   phase = 0;
    initial serial_read_o = 1'b0;
    // idle cells toggle so a stale level never passes for data
    always @(posedge sys_clk_i)
    begin
        #2;
        if (phase == 0 && q.size() != 0)
            serial_read_o = q.pop_front();
        else if (phase == 0)
            serial_read_o = ~serial_read_o;
        phase = (phase + 1) % BIT_DIV;
    end
    // queue a field msb first, return once its last cell is over
    task automatic send(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            q.push_back(v[i]);
        wait (q.size() == 0);
        repeat (BIT_DIV) @(posedge sys_clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
`default_nettype none
module testbench;
    import dsp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------
    // stimulus and checks
    // ----------
    localparam int BD = 4;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic        io_rd_i = 1'b0;
    logic        io_wr_i = 1'b0;
    logic [15:0] io_wdata_i = 16'h0000;
    logic        read_gate_i = 1'b0;
    logic        ecc_window_i = 1'b0;
    logic        id_field_i = 1'b0;
    logic [7:0]  drive_status_i = 8'hA5;
    logic [5:0]  ctrl_status_i = 6'h2D;
    logic [5:0]  aux_status_i = 6'h29;
    logic [15:0] internal_bus_lines_o;
    logic        serial_read_i;
    logic        sync_locked_o;
    logic        word_load_strobe_o;
    logic        latched_mismatch_o;
    logic [15:0] rd_data;
    logic [15:0] exp_st = 16'hA5B4;
    logic [15:0] exp_ax = 16'hA400;
    int          error_cnt = 0;
    int          checks_done = 0;
    // write side stays idle: only the read path is exercised
    dsp_core #(.BIT_DIV(BD)) u_dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i),
        .io_wdata_i(io_wdata_i),
        .internal_bus_lines_o(internal_bus_lines_o),
        .read_gate_i(read_gate_i), .write_transfer_n_i(1'b1),
        .delayed_write_transfer_i(1'b0), .ecc_window_i(ecc_window_i),
        .id_field_i(id_field_i), .addr_mark_mode_i(1'b0),
        .serial_read_i(serial_read_i), .serial_write_stream_o(),
        .drive_status_i(drive_status_i), .ctrl_status_i(ctrl_status_i),
        .aux_status_i(aux_status_i), .sync_locked_o(sync_locked_o),
        .word_load_strobe_o(word_load_strobe_o),
        .latched_mismatch_o(latched_mismatch_o));
    dsp_drive_model #(.BIT_DIV(BD)) u_drv (
        .sys_clk_i(sys_clk_i), .serial_read_o(serial_read_i));
    always #10 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one port access, read data lands in rd_data
    task automatic io_cycle(input logic wr, input logic [15:0] addr,
                            input logic [15:0] wdata);
        @(posedge sys_clk_i);
        #1;
        io_wr_i = wr;
        io_rd_i = !wr;
        io_addr_i = addr;
        io_wdata_i = wdata;
        @(posedge sys_clk_i);
        #1;
        io_wr_i = 1'b0;
        io_rd_i = 1'b0;
        rd_data = internal_bus_lines_o;
    endtask
    // id field with zero check bytes, then verdict and status bit 6
    task automatic id_field(input logic [31:0] disk_id, input logic mm);
        read_gate_i = 1'b1;
        id_field_i = 1'b1;
        u_drv.send({24'h0, DSP_SYNC_STD}, 8);
        u_drv.send(disk_id, 32);
        ecc_window_i = 1'b1;
        u_drv.send(32'h0, 32);
        ecc_window_i = 1'b0;
        read_gate_i = 1'b0;
        repeat (20) @(negedge sys_clk_i);
        check({15'h0, latched_mismatch_o}, {15'h0, mm});
        io_cycle(1'b0, DSP_ADDR_STATUS, 16'h0000);
        check(rd_data & 16'h0040, {9'h0, mm, 6'h0});
    endtask
    task automatic report_and_stop;
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b0;
        check({13'h0, sync_locked_o, word_load_strobe_o,
               latched_mismatch_o}, 16'h0000);
        // second pass reads every status input inverted
        for (int i = 0; i < 2; i++)
        begin
            repeat (4) @(posedge sys_clk_i);
            io_cycle(1'b0, DSP_ADDR_STATUS, 16'h0000);
            check(rd_data & 16'hFFBC, exp_st);
            io_cycle(1'b0, DSP_ADDR_AUX, 16'h0000);
            check(rd_data, exp_ax);
            drive_status_i = ~drive_status_i;
            ctrl_status_i = ~ctrl_status_i;
            aux_status_i = ~aux_status_i;
            exp_st = ~exp_st & 16'hFFBC;
            exp_ax = ~exp_ax & 16'hFC00;
        end
        io_cycle(1'b0, 16'h9000, 16'h0000);
        check(rd_data, 16'h0000);
        io_cycle(1'b1, DSP_ADDR_DATA, 16'hFFFF);
        io_cycle(1'b1, DSP_ADDR_ID_LO, 16'h0000);
        io_cycle(1'b1, DSP_ADDR_ID_HI, 16'h0000);
        id_field(32'h00000001, 1'b1);
        id_field(32'h00000000, 1'b0);
        // data field: word must reach the buffer after lock
        read_gate_i = 1'b1;
        id_field_i = 1'b0;
        fork
            u_drv.send({8'h0, DSP_SYNC_STD, 16'hA5C3}, 24);
        join_none
        for (int i = 0; i < 400 && word_load_strobe_o !== 1'b1; i++)
            @(negedge sys_clk_i);
        check({15'h0, word_load_strobe_o}, 16'h0001);
        check({15'h0, sync_locked_o}, 16'h0001);
        io_cycle(1'b0, DSP_ADDR_DATA, 16'h0000);
        check(rd_data, 16'hA5C3);
        read_gate_i = 1'b0;
        report_and_stop();
    end
    // whole run is under a thousand cycles; this only cuts a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        report_and_stop();
    end
endmodule
bind dsp_core dsp_checker u_chk (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .internal_bus_lines_o(internal_bus_lines_o),
    .ecc_window_i(ecc_window_i), .drive_status_i(drive_status_i),
    .ctrl_status_i(ctrl_status_i), .aux_status_i(aux_status_i),
    .sync_locked_o(sync_locked_o),
    .word_load_strobe_o(word_load_strobe_o),
    .latched_mismatch_o(latched_mismatch_o));
`default_nettype wire
